//--- hdl/afc_top.sv
// converter control: clock divide, power state, output bus and coding
`timescale 1ns/1ns
// Operation
// - divider strap low gives 2, floating gives 1, high gives 4.
// - divide ratio written over the configuration port beats the strap.
// - after a clock rate change, relock may take 52 us, scaled by rate.
// - clock generator has slow and default fast range; controller picks.
// - output bus differential (default) or single-ended, SDR default or DDR.
// - differential drive is 3 mA by default or 2 mA to save power.
// - output mode, rate and drive set by a write to address 0x73.
// - in nap or sleep all data, clock and over-range outputs float.
// - after power-up the power strap picks normal, sleep or nap.
// - power state written over the configuration port beats the strap.
// - coding is two's complement by default, or Gray or offset binary.
// - offset binary runs from all zeros to all ones, mid-scale top bit.
// - two's complement is offset binary with its top bit inverted.
// - Gray keeps top bit, lower bits xor with next higher binary bit.
// - Gray mid-scale gives two top bits, full positive only top bit.
// - with divide 2 or 4 output clock stays low during calibration reset.
// - during calibration the data outputs show the fixed 0x0CCC pattern, the low 14 bits of 0xCCCC.
module afc_top
   import afc_pkg::*;
#(
   parameter int RELOCK_CYC = AFC_RELOCK_CYC,
   parameter int CAL_CYC    = AFC_CAL_CYC
) (
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire logic [1:0]        clock_divide_strap,
   input  wire logic [1:0]        power_state_strap,
   input  wire logic              serial_select_n,
   input  wire logic              cfg_wr,
   input  wire logic [7:0]        cfg_addr,
   input  wire logic [7:0]        cfg_data,
   input  wire logic              calibration_reset_n,
   input  wire logic              divider_phase_reset,
   input  wire logic [AFC_DW-1:0] core_data,
   input  wire logic              core_over_range,
   input  wire logic              core_valid,
   output logic                   core_ready,
   input  wire logic              capture_ready,
   output logic [AFC_DW-1:0]      out_data,
   output logic                   out_data_oe,
   output logic                   sample_output_clock,
   output logic                   sample_output_clock_oe,
   output logic                   out_over_range,
   output logic                   out_over_range_oe,
   output logic                   out_cmos_mode,
   output logic                   out_ddr_mode,
   output logic                   out_low_drive,
   output logic                   dll_slow_range,
   output logic                   dll_locked,
   output logic                   cal_done,
   output logic [1:0]             divide_ratio,
   output logic [1:0]             power_state
);
   localparam int FW = AFC_DW + 1;

   // tri-level strap decode, used for both straps
   function automatic logic [1:0] strap_sel(input logic [1:0] s,
                                            input logic [1:0] lo,
                                            input logic [1:0] fl,
                                            input logic [1:0] hi);
      logic [1:0] r;
      r = fl;
      if (s == AFC_STRAP_LOW) begin
         r = lo;
      end else if (s == AFC_STRAP_HIGH) begin
         r = hi;
      end
      return r;
   endfunction : strap_sel

   // configuration state
   logic       straps_taken_r;
   afc_div_t   div_r;
   afc_div_t   div_nxt;
   afc_pwr_t   pwr_r;
   afc_pwr_t   pwr_nxt;
   afc_fmt_t   fmt_r;
   logic       ddr_r;
   logic       cmos_r;
   logic       lowi_r;
   logic       slow_r;
   // clocking and calibration state
   logic [2:0]  div_cnt_r;
   logic [31:0] relock_r;
   logic        locked_r;
   logic        cal_rst_q_r;
   logic        cal_busy_r;
   logic [31:0] cal_cnt_r;
   // output stage
   logic [AFC_DW-1:0] dout_r;
   logic              dout_oe_r;
   logic              oclk_r;
   logic              or_r;
   logic              half_r;

   // configuration port decode
   wire wr_out = cfg_wr && (cfg_addr == AFC_ADDR_OUT);
   wire wr_div = cfg_wr && (cfg_addr == AFC_ADDR_DIV);
   wire wr_pwr = cfg_wr && (cfg_addr == AFC_ADDR_PWR);
   wire wr_dll = cfg_wr && (cfg_addr == AFC_ADDR_DLL);
   wire [1:0] div_fld = cfg_data[AFC_DIV_LSB +: 2];
   wire [1:0] pwr_fld = cfg_data[AFC_PWR_LSB +: 2];
   wire [1:0] fmt_fld = cfg_data[AFC_OUT_FMT_LSB +: 2];

   // strap choices
   wire [1:0] div_strap = strap_sel(clock_divide_strap, AFC_DIV_2,
                                    AFC_DIV_1, AFC_DIV_4);
   wire [1:0] pwr_strap = strap_sel(power_state_strap, AFC_PWR_NORMAL,
                                    AFC_PWR_SLEEP, AFC_PWR_NAP);

   // the port value wins over the strap once written; reserved codes ignored
   assign div_nxt = !straps_taken_r ? afc_div_t'(div_strap) :
                    (wr_div && div_fld != 2'h3) ? afc_div_t'(div_fld) :
                    div_r;
   assign pwr_nxt = !straps_taken_r ? afc_pwr_t'(pwr_strap) :
                    (wr_pwr && pwr_fld != 2'h3) ? afc_pwr_t'(pwr_fld) :
                    pwr_r;

   // straps are caught once, at the first edge after reset release
   always_ff @(posedge mclk) begin
      if (rst) begin
         straps_taken_r <= 1'b0;
         div_r          <= AFC_DIV_1;
         pwr_r          <= AFC_PWR_NORMAL;
      end else begin
         straps_taken_r <= 1'b1;
         div_r          <= div_nxt;
         pwr_r          <= pwr_nxt;
      end
   end

   // output mode byte and clock generator range
   always_ff @(posedge mclk) begin
      if (rst) begin
         fmt_r  <= AFC_FMT_RST;
         ddr_r  <= AFC_DDR_RST;
         cmos_r <= AFC_CMOS_RST;
         lowi_r <= AFC_LOWI_RST;
         slow_r <= AFC_SLOW_RST;
      end else begin
         if (wr_out) begin
            ddr_r  <= cfg_data[AFC_OUT_DDR_BIT];
            cmos_r <= cfg_data[AFC_OUT_CMOS_BIT];
            lowi_r <= cfg_data[AFC_OUT_LOWI_BIT];
            if (fmt_fld != 2'h3) begin
               fmt_r <= afc_fmt_t'(fmt_fld);
            end
         end
         if (wr_dll) begin
            slow_r <= cfg_data[AFC_DLL_SLOW_BIT];
         end
      end
   end

   // sample strobe from the divided clock
   wire [2:0] div_last = (div_r == AFC_DIV_4) ? 3'h3 :
                         (div_r == AFC_DIV_2) ? 3'h1 : 3'h0;
   wire       strobe   = (div_cnt_r == 3'h0);

   always_ff @(posedge mclk) begin
      if (rst || divider_phase_reset) begin
         div_cnt_r <= 3'h0;
      end else if (div_cnt_r >= div_last) begin
         div_cnt_r <= 3'h0;
      end else begin
         div_cnt_r <= div_cnt_r + 3'h1;
      end
   end

   // relock time scales with the divide ratio, i.e. inversely with rate
   wire        rate_change = straps_taken_r && (div_nxt != div_r);
   wire [31:0] relock_load = (div_nxt == AFC_DIV_4) ? 32'(RELOCK_CYC * 4) :
                             (div_nxt == AFC_DIV_2) ? 32'(RELOCK_CYC * 2) :
                             32'(RELOCK_CYC);

   always_ff @(posedge mclk) begin
      if (rst) begin
         relock_r <= 32'h0;
      end else if (rate_change) begin
         relock_r <= relock_load;
      end else if (relock_r != 32'h0) begin
         relock_r <= relock_r - 32'h1;
      end
   end

   // lock flag as its own flop: high exactly when the count reads zero
   always_ff @(posedge mclk) begin
      if (rst) begin
         locked_r <= 1'b1;
      end else begin
         locked_r <= !rate_change && (relock_r <= 32'h1);
      end
   end

   // calibration runs after reset and after every rising calibration reset
   wire cal_rise = calibration_reset_n && !cal_rst_q_r;

   always_ff @(posedge mclk) begin
      if (rst) begin
         cal_rst_q_r <= 1'b0;
         cal_busy_r  <= 1'b1;
         cal_cnt_r   <= 32'h0;
      end else begin
         cal_rst_q_r <= calibration_reset_n;
         if (!calibration_reset_n || cal_rise) begin
            cal_busy_r <= 1'b1;
            cal_cnt_r  <= 32'(CAL_CYC);
         end else if (cal_cnt_r > 32'h1) begin
            cal_cnt_r <= cal_cnt_r - 32'h1;
         end else begin
            cal_cnt_r  <= 32'h0;
            cal_busy_r <= 1'b0;
         end
      end
   end

   // coding is combinational ahead of the fifo, adding no latency
   wire [AFC_DW-1:0] obin = core_data;
   wire [AFC_DW-1:0] twos = {~obin[AFC_DW-1], obin[AFC_DW-2:0]};
   wire [AFC_DW-1:0] gray = obin ^ (obin >> 1);
   wire [AFC_DW-1:0] coded = (fmt_r == AFC_FMT_GRAY)   ? gray :
                             (fmt_r == AFC_FMT_OFFSET) ? obin :
                             twos;

   // the core is stalled by the fifo; a full fifo drops core_ready
   wire          fifo_in_ready;
   wire          fifo_out_valid;
   wire [FW-1:0] fifo_out_data;
   wire          active   = (pwr_r == AFC_PWR_NORMAL);
   wire          push_ok  = strobe && core_valid && active;
   wire          emit_ok  = active && capture_ready;
   wire          pop      = emit_ok && (!ddr_r || half_r);

   assign core_ready = fifo_in_ready && strobe && active;

   afc_fifo #(
      .WIDTH (FW),
      .DEPTH (AFC_FIFO_DEPTH)
   ) afc_fifo_inst (
      .mclk      (mclk),
      .rst       (rst),
      .in_valid  (push_ok),
      .in_ready  (fifo_in_ready),
      .in_data   ({core_over_range, coded}),
      .out_valid (fifo_out_valid),
      .out_ready (pop),
      .out_data  (fifo_out_data)
   );

   // ddr sends low half then high half on the lower lines
   wire [AFC_DW-1:0] word    = fifo_out_data[AFC_DW-1:0];
   wire [AFC_DW-1:0] ddr_word = half_r ?
        {{AFC_DW-AFC_HW{1'b0}}, word[AFC_DW-1:AFC_HW]} :
        {{AFC_DW-AFC_HW{1'b0}}, word[AFC_HW-1:0]};
   wire [AFC_DW-1:0] send    = cal_busy_r ? AFC_CAL_PATTERN[AFC_DW-1:0] :
                               ddr_r ? ddr_word : word;
   wire              go      = emit_ok && fifo_out_valid;
   wire              hold_lo = !calibration_reset_n && (div_r != AFC_DIV_1);

   // output stage: all bus pins come from flops
   always_ff @(posedge mclk) begin
      if (rst) begin
         dout_r    <= '0;
         dout_oe_r <= 1'b0;
         oclk_r    <= 1'b0;
         or_r      <= 1'b0;
         half_r    <= 1'b0;
      end else begin
         // stay off until the strap power state has been taken
         dout_oe_r <= straps_taken_r && active;
         if (hold_lo) begin
            oclk_r <= 1'b0;
         end else if (go) begin
            oclk_r <= ~oclk_r;
         end
         if (go) begin
            dout_r <= send;
            or_r   <= fifo_out_data[AFC_DW];
            half_r <= ddr_r ? ~half_r : 1'b0;
         end else if (cal_busy_r) begin
            dout_r <= AFC_CAL_PATTERN[AFC_DW-1:0];
         end
         if (!ddr_r) begin
            half_r <= 1'b0;
         end
      end
   end

   // status mirrors; nap or sleep releases every bus pin
   assign out_data               = dout_r;
   assign out_data_oe            = dout_oe_r;
   assign sample_output_clock    = oclk_r;
   assign sample_output_clock_oe = dout_oe_r;
   assign out_over_range         = or_r;
   assign out_over_range_oe      = dout_oe_r;
   assign out_cmos_mode          = cmos_r;
   assign out_ddr_mode           = ddr_r;
   assign out_low_drive          = lowi_r && !cmos_r;
   assign dll_slow_range         = slow_r;
   assign dll_locked             = locked_r;
   assign cal_done               = !cal_busy_r;
   assign divide_ratio           = div_r;
   assign power_state            = pwr_r;
endmodule : afc_top

//--- inc/afc_pkg.sv
// shared constants and types for the converter output format control
package afc_pkg;
   // configuration addresses seen by the serial configuration port
   localparam logic [7:0] AFC_ADDR_OUT = 8'h73;
   localparam logic [7:0] AFC_ADDR_DIV = 8'h72;
   localparam logic [7:0] AFC_ADDR_PWR = 8'h25;
   localparam logic [7:0] AFC_ADDR_DLL = 8'h74;
   // field positions in the output-mode byte
   localparam int AFC_OUT_DDR_BIT  = 0;
   localparam int AFC_OUT_CMOS_BIT = 1;
   localparam int AFC_OUT_LOWI_BIT = 2;
   localparam int AFC_OUT_FMT_LSB  = 4;
   // field positions in divider, power and clock-range bytes
   localparam int AFC_DIV_LSB     = 0;
   localparam int AFC_PWR_LSB     = 0;
   localparam int AFC_DLL_SLOW_BIT = 0;
   // tri-level strap encoding
   localparam logic [1:0] AFC_STRAP_LOW   = 2'h0;
   localparam logic [1:0] AFC_STRAP_FLOAT = 2'h1;
   localparam logic [1:0] AFC_STRAP_HIGH  = 2'h2;
   // sample word
   localparam int AFC_DW = 14;
   localparam int AFC_HW = 7;
   localparam logic [15:0] AFC_CAL_PATTERN = 16'hcccc;
   localparam int AFC_FIFO_DEPTH = 8;
   // timing, at 125 MHz mclk
   localparam int AFC_CLK_PERIOD_NS = 8;
   localparam int AFC_RELOCK_NS     = 52000;
   localparam int AFC_RELOCK_CYC    = AFC_RELOCK_NS / AFC_CLK_PERIOD_NS;
   localparam int AFC_CAL_MS        = 200;
   localparam int AFC_CAL_CYC       =
      (AFC_CAL_MS * 1000000) / AFC_CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      AFC_FMT_TWOS,
      AFC_FMT_GRAY,
      AFC_FMT_OFFSET
   } afc_fmt_t;
   typedef enum logic [1:0] {
      AFC_PWR_NORMAL,
      AFC_PWR_NAP,
      AFC_PWR_SLEEP
   } afc_pwr_t;
   typedef enum logic [1:0] {
      AFC_DIV_1,
      AFC_DIV_2,
      AFC_DIV_4
   } afc_div_t;
   // reset values
   localparam afc_fmt_t AFC_FMT_RST = AFC_FMT_TWOS;
   localparam logic AFC_DDR_RST  = 1'b0;
   localparam logic AFC_CMOS_RST = 1'b0;
   localparam logic AFC_LOWI_RST = 1'b0;
   localparam logic AFC_SLOW_RST = 1'b0;
endpackage : afc_pkg

//--- hdl/afc_fifo.sv
// sample fifo with its own memory and registered read data
`timescale 1ns/1ns
module afc_fifo #(
   parameter int WIDTH = 15,
   parameter int DEPTH = 8
) (
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_r;
   logic [AW-1:0]    rd_r;
   logic [AW:0]      cnt_r;
   logic [AW:0]      cnt_nxt;
   logic             out_valid_r;
   logic [WIDTH-1:0] out_data_r;
   wire              push;
   wire              load;

   // memory holds DEPTH words, the output register one more
   assign in_ready  = (cnt_r < (AW+1)'(DEPTH));
   assign push      = in_valid && in_ready;
   assign load      = (cnt_r != '0) && (!out_valid_r || out_ready);
   assign cnt_nxt   = cnt_r + (AW+1)'(push) - (AW+1)'(load);
   assign out_valid = out_valid_r;
   assign out_data  = out_data_r;

   // write side
   always_ff @(posedge mclk) begin
      if (push) begin
         mem_r[wr_r] <= in_data;
      end
      if (rst) begin
         wr_r <= '0;
      end else if (push) begin
         wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      end
   end

   // read side, data leave through a register
   always_ff @(posedge mclk) begin
      if (rst) begin
         rd_r        <= '0;
         cnt_r       <= '0;
         out_valid_r <= 1'b0;
         out_data_r  <= '0;
      end else begin
         cnt_r <= cnt_nxt;
         if (load) begin
            out_data_r  <= mem_r[rd_r];
            out_valid_r <= 1'b1;
            rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
         end else if (out_ready) begin
            out_valid_r <= 1'b0;
         end
      end
   end
endmodule : afc_fifo

//--- hdl/afc_note_fix.sv
// no logic here: the block lives in afc_top and afc_fifo

//--- verification/afc_top_monitor.sv
// checker on the output format control top-level ports
`timescale 1ns/1ns
module afc_top_monitor
   import afc_pkg::*;
(
   input wire logic              mclk,
   input wire logic              rst,
   input wire logic              cfg_wr,
   input wire logic [7:0]        cfg_addr,
   input wire logic [7:0]        cfg_data,
   input wire logic              calibration_reset_n,
   input wire logic [AFC_DW-1:0] out_data,
   input wire logic              out_data_oe,
   input wire logic              sample_output_clock,
   input wire logic              out_cmos_mode,
   input wire logic              out_ddr_mode,
   input wire logic              out_low_drive,
   input wire logic              cal_done,
   input wire logic [1:0]        divide_ratio,
   input wire logic [1:0]        power_state
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   // oe is registered, so one cycle of grace after entering low power
   a_oe_power: assert property (
      (power_state != 2'h0) [*2] |-> !out_data_oe)
      else $error("data bus driven in low power");
   a_cfg_mode: assert property (
      cfg_wr && cfg_addr == AFC_ADDR_OUT |=>
      {out_cmos_mode, out_ddr_mode} == $past(cfg_data[1:0]))
      else $error("bus mode not taken from write");
   a_low_write: assert property (
      cfg_wr && cfg_addr == AFC_ADDR_OUT |=>
      out_low_drive == ($past(cfg_data[2]) && !$past(cfg_data[1])))
      else $error("drive current not taken from write");
   a_low_cmos: assert property (
      out_cmos_mode |-> !out_low_drive)
      else $error("reduced drive in single-ended mode");
   a_div_write: assert property (
      cfg_wr && cfg_addr == AFC_ADDR_DIV && cfg_data[1:0] != 2'h3 |=>
      divide_ratio == $past(cfg_data[1:0]))
      else $error("written divide ratio not applied");
   a_pwr_write: assert property (
      cfg_wr && cfg_addr == AFC_ADDR_PWR && cfg_data[1:0] != 2'h3 |=>
      power_state == $past(cfg_data[1:0]))
      else $error("written power state not applied");
   a_cal_pattern: assert property (
      (!cal_done) [*4] |-> !out_data_oe || out_data == 14'h0ccc)
      else $error("converted data shown during calibration");
   a_clk_held: assert property (
      (!calibration_reset_n && divide_ratio != 2'h0) [*2] |->
      !sample_output_clock)
      else $error("output clock runs in calibration reset");
endmodule : afc_top_monitor

bind afc_top afc_top_monitor afc_top_monitor_inst (.*);

//--- verification/afc_capture_model.sv
// capture logic model on the far side of the parallel sample bus
`timescale 1ns/1ns
module afc_capture_model
   import afc_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire logic [AFC_DW-1:0] out_data,
   input  wire logic              out_data_oe,
   input  wire logic              sample_output_clock,
   input  wire logic [1:0]        stall_mode,
   output logic                   capture_ready
);
   logic              phase_r;
   logic              clk_seen_r;
   logic [AFC_DW-1:0] got[$];

   // mode 0 ready, 1 ready every other cycle, 2 stalled; a word is
   // latched on each output clock transition while the bus is driven
   always @(posedge mclk) begin
      phase_r <= rst ? 1'b0 : ~phase_r;
      capture_ready <= stall_mode == 2'h0 || (stall_mode == 2'h1 && phase_r);
      if (!rst && out_data_oe && sample_output_clock !== clk_seen_r)
         got.push_back(out_data);
      clk_seen_r <= sample_output_clock;
   end
endmodule : afc_capture_model

//--- verification/adc_output_format_control_tb.sv
// self-checking bench for the converter output format control
`timescale 1ns/1ns
module adc_output_format_control_tb;
   import afc_pkg::*;
   logic              mclk, rst, serial_select_n, cfg_wr, core_valid;
   logic              calibration_reset_n, divider_phase_reset;
   logic              core_over_range, core_ready, capture_ready;
   logic              out_data_oe, sample_output_clock, out_over_range;
   logic              sample_output_clock_oe, out_over_range_oe;
   logic              out_cmos_mode, out_ddr_mode, out_low_drive;
   logic              dll_slow_range, dll_locked, cal_done;
   logic [1:0]        clock_divide_strap, power_state_strap;
   logic [1:0]        divide_ratio, power_state, stall_mode;
   logic [7:0]        cfg_addr, cfg_data;
   logic [AFC_DW-1:0] core_data, out_data;
   int                bad_count, checks_done;

   // short relock and calibration counts keep the run brief
   afc_top #(.RELOCK_CYC(20), .CAL_CYC(30)) afc_top_inst (.*);
   afc_capture_model afc_capture_model_inst (.*);

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic chk(input string nm, input logic [15:0] exp, got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim

   // one configuration byte, checked after the status edge
   task automatic wr(input logic [7:0] a, d);
      @(posedge mclk);
      cfg_wr <= 1'b1;
      cfg_addr <= a;
      cfg_data <= d;
      @(posedge mclk);
      cfg_wr <= 1'b0;
      repeat (2) @(negedge mclk);
   endtask : wr

   task automatic do_reset(input logic [1:0] ds, ps, input int n);
      @(posedge mclk);
      rst <= 1'b1;
      clock_divide_strap <= ds;
      power_state_strap <= ps;
      repeat (n) @(posedge mclk);
      rst <= 1'b0;
      repeat (4) @(negedge mclk);
   endtask : do_reset

   task automatic wait_hi(input string nm, ref logic s);
      for (int k = 0; k < 400 && s !== 1'b1; k++)
         @(negedge mclk);
      chk(nm, 1, s);
   endtask : wait_hi

   // hold the word until taken; eight cycles without ready is a refusal
   task automatic send(input logic [AFC_DW-1:0] w, output logic ok);
      @(posedge mclk);
      core_valid <= 1'b1;
      core_data <= w;
      core_over_range <= (w == 14'h3fff); // full scale flagged as over range
      ok = 1'b0;
      for (int k = 0; k < 8 && !ok; k++) begin
         @(negedge mclk);
         ok = core_ready === 1'b1;
      end
      @(posedge mclk);
      core_valid <= 1'b0;
   endtask : send

   task automatic drain(input int n);
      for (int k = 0; k < 400 && afc_capture_model_inst.got.size() < n; k++)
         @(negedge mclk);
      chk("captured", n, afc_capture_model_inst.got.size());
   endtask : drain

   function automatic logic [13:0] enc(input logic [13:0] ob, input int f);
      case (f)
         0: return ob ^ 14'h2000;
         1: return ob ^ (ob >> 1);
         default: return ob;
      endcase
   endfunction : enc

   task automatic t_straps();
      logic [1:0] st[3] = '{AFC_STRAP_LOW, AFC_STRAP_FLOAT, AFC_STRAP_HIGH};
      logic [1:0] dv[3] = '{AFC_DIV_2, AFC_DIV_1, AFC_DIV_4};
      logic [1:0] pw[3] = '{AFC_PWR_NORMAL, AFC_PWR_SLEEP, AFC_PWR_NAP};
      for (int i = 0; i < 3; i++) begin
         do_reset(st[i], st[i], 2);
         chk("divide_ratio", dv[i], divide_ratio);
         chk("power_state", pw[i], power_state);
      end
      do_reset(AFC_STRAP_FLOAT, AFC_STRAP_LOW, 2);
      chk("bus_mode", 0, {out_cmos_mode, out_ddr_mode});
      chk("low_drive", 0, out_low_drive);
      chk("slow_range", 0, dll_slow_range);
   endtask : t_straps

   // table inputs through each coding; the first pass uses the default
   task automatic t_fmt();
      logic [13:0] ob[5] = '{14'h0, 14'h1, 14'h2000, 14'h3ffe, 14'h3fff};
      logic        ok;
      for (int f = 0; f < 3; f++) begin
         if (f > 0)
            wr(AFC_ADDR_OUT, 8'(f << 4));
         afc_capture_model_inst.got.delete();
         foreach (ob[i])
            send(ob[i], ok);
         drain(5);
         chk("over_range", 1, out_over_range);
         foreach (ob[i])
            chk("sample", enc(ob[i], f),
                afc_capture_model_inst.got[i]);
      end
   endtask : t_fmt

   task automatic t_fifo();
      int   n;
      logic ok;
      n = 0;
      afc_capture_model_inst.got.delete();
      @(posedge mclk);
      stall_mode <= 2'h2;
      do begin
         send(14'(n * 5 + 3), ok);
         n += int'(ok);
      end while (ok && n < 16);
      chk("fifo_refusal", 1, n >= AFC_FIFO_DEPTH && n < 16);
      @(posedge mclk);
      stall_mode <= 2'h0;
      drain(n);
      chk("over_range", 0, out_over_range);
      for (int k = 0; k < n; k++)
         chk("drained", 14'(k * 5 + 3), afc_capture_model_inst.got[k]);
   endtask : t_fifo

   // one word over the half-width bus: low half first, then high half
   task automatic t_ddr();
      logic ok;
      wr(AFC_ADDR_OUT, 8'h21);
      afc_capture_model_inst.got.delete();
      send(14'h2a5b, ok);
      drain(2);
      chk("ddr_low", 14'h005b, afc_capture_model_inst.got[0]);
      chk("ddr_high", 14'h0054, afc_capture_model_inst.got[1]);
      wr(AFC_ADDR_OUT, 8'h20);
   endtask : t_ddr

   task automatic t_cal();
      wr(AFC_ADDR_DIV, 8'h01);
      wait_hi("dll_locked", dll_locked);
      @(posedge mclk);
      calibration_reset_n <= 1'b0;
      repeat (2) @(posedge mclk);
      repeat (4) begin
         @(negedge mclk);
         chk("out_clock", 0, sample_output_clock);
      end
      @(posedge mclk);
      calibration_reset_n <= 1'b1;
      repeat (4) @(negedge mclk);
      chk("cal_pattern", 14'h0ccc, out_data);
      chk("cal_done", 0, cal_done);
      wait_hi("cal_done", cal_done);
      wr(AFC_ADDR_DIV, 8'h00);
      wait_hi("dll_locked", dll_locked);
   endtask : t_cal

   task automatic t_cfg();
      logic [1:0] pv[3] = '{AFC_PWR_NAP, AFC_PWR_SLEEP, AFC_PWR_NORMAL};
      wr(AFC_ADDR_OUT, 8'h07);
      chk("bus_mode", 3, {out_cmos_mode, out_ddr_mode});
      chk("low_drive", 0, out_low_drive);
      wr(AFC_ADDR_OUT, 8'h04);
      chk("low_drive", 1, out_low_drive);
      wr(8'h10, 8'hff);
      chk("ddr", 0, out_ddr_mode);
      wr(AFC_ADDR_DLL, 8'h01);
      chk("slow_range", 1, dll_slow_range);
      wr(AFC_ADDR_DIV, 8'h02);
      chk("divide_ratio", AFC_DIV_4, divide_ratio);
      chk("dll_locked", 0, dll_locked);
      wait_hi("dll_locked", dll_locked);
      foreach (pv[i]) begin
         wr(AFC_ADDR_PWR, {6'h0, pv[i]});
         chk("power_state", pv[i], power_state);
         if (pv[i] != AFC_PWR_NORMAL)
            chk("bus_oe", 0, {out_data_oe, sample_output_clock_oe,
                out_over_range_oe});
      end
   endtask : t_cfg

   initial begin
      rst = 1'b1;
      {cfg_wr, cfg_addr, cfg_data, divider_phase_reset} = '0;
      {core_data, core_over_range, core_valid} = '0;
      clock_divide_strap = AFC_STRAP_FLOAT;
      power_state_strap = AFC_STRAP_LOW;
      serial_select_n = 1'b1;
      calibration_reset_n = 1'b1;
      stall_mode = 2'h1;
      do_reset(AFC_STRAP_FLOAT, AFC_STRAP_LOW, 20);
      t_straps();
      wait_hi("cal_done", cal_done);
      t_fmt();
      t_fifo();
      t_ddr();
      t_cal();
      t_cfg();
      end_sim();
   end

   // hang guard, well beyond the several hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge mclk);
      bad_count++;
      end_sim();
   end
endmodule : adc_output_format_control_tb
